/* File: fpec_pkg.sv */
package fpec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned CTL_W = 16;         // Control register width
  localparam int unsigned ADDR_W = 24;        // Program address width
  localparam int unsigned INSTR_W = 24;       // Instruction word width
  localparam int unsigned LATCH_IDX_W = 6;    // Index into 64 holding latches
  localparam int unsigned ROW_WORDS = 64;     // Holding latches per row
  localparam int unsigned CNT_W = 16;         // Operation timer width

  // ----------------------------------------------------------------
  // Control register field layout
  // ----------------------------------------------------------------
  localparam int unsigned CTL_START_BIT = 15; // Start, hardware cleared
  localparam int unsigned CTL_EN_BIT = 14;    // Write enable
  localparam int unsigned CTL_ERR_BIT = 13;   // Sequence error flag
  localparam int unsigned CTL_ERASE_BIT = 6;  // Erase/program select
  localparam int unsigned CTL_OP_LSB = 0;     // Operation code low bit
  localparam int unsigned CTL_OP_W = 4;       // Operation code width
  localparam logic [15:0] CTL_RESET = 16'h0000; // Power-on value

  // ----------------------------------------------------------------
  // Operation codes and unlock keys
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_ROW = 4'h1;       // Program one row
  localparam logic [3:0] OP_PAGE = 4'h2;      // Erase one page
  localparam logic [3:0] OP_WORD = 4'h3;      // Program one word
  localparam logic [3:0] OP_BULK = 4'hF;      // Bulk erase
  localparam logic [7:0] KEY_FIRST = 8'h55;   // First unlock value
  localparam logic [7:0] KEY_SECOND = 8'hAA;  // Second unlock value

  // ----------------------------------------------------------------
  // Address alignment (two address units per instruction)
  // ----------------------------------------------------------------
  localparam int unsigned LATCH_IDX_LSB = 1;  // Latch index starts above bit 0
  localparam logic [23:0] ROW_MASK = 24'hFFFF80;  // 64-instruction row
  localparam logic [23:0] PAGE_MASK = 24'hFFFC00; // 512-instruction page
  localparam logic [23:0] ERASED_WORD = 24'hFFFFFF; // Latch value after reset

  // ----------------------------------------------------------------
  // Link register select
  // ----------------------------------------------------------------
  localparam logic REG_SEL_CTRL = 1'b0;       // Control register
  localparam logic REG_SEL_KEY = 1'b1;        // Unlock key register

  // ----------------------------------------------------------------
  // Software map of the core end (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] HOST_OFS_CTRL = 5'h00;  // Control read/write
  localparam logic [4:0] HOST_OFS_KEY = 5'h04;   // Key write
  localparam logic [4:0] HOST_OFS_TADDR = 5'h08; // Table pointer
  localparam logic [4:0] HOST_OFS_TDATA = 5'h0C; // Table write data
  localparam logic [4:0] HOST_OFS_STAT = 5'h10;  // Core status
  localparam int unsigned STAT_STALL_BIT = 0;    // Stall seen on link
  localparam logic [1:0] HOST_NOP_SLOTS = 2'h2;  // Idle slots after reg write
  localparam logic [23:0] TBL_ADDR_STEP = 24'h000002; // Pointer step

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    FPEC_K_NONE = 5'h01,
    FPEC_K_WORD = 5'h02,
    FPEC_K_ROW = 5'h04,
    FPEC_K_PAGE = 5'h08,
    FPEC_K_BULK = 5'h10
  } fpec_kind_t;

  typedef enum logic [2:0] {
    FPEC_KS_IDLE = 3'h1,
    FPEC_KS_FIRST = 3'h2,
    FPEC_KS_ARMED = 3'h4
  } fpec_key_t;

  typedef enum logic [1:0] {
    FPEC_DS_IDLE = 2'h1,
    FPEC_DS_BUSY = 2'h2
  } fpec_dstate_t;

  // Map code and erase select onto an operation, none when mismatched
  function automatic fpec_kind_t fpec_decode(input logic [3:0] op, input logic erase,
                                             input logic bulk_ok);
    fpec_kind_t k;
    k = FPEC_K_NONE;
    if (op == OP_WORD && !erase) begin
      k = FPEC_K_WORD;
    end else if (op == OP_ROW && !erase) begin
      k = FPEC_K_ROW;
    end else if (op == OP_PAGE && erase) begin
      k = FPEC_K_PAGE;
    end else if (op == OP_BULK && erase && bulk_ok) begin
      k = FPEC_K_BULK;
    end
    return k;
  endfunction : fpec_decode

endpackage : fpec_pkg

/* File: fpec_if.sv */
// --------------------------------------------------------------------
// Link between processor core end and flash controller end
// --------------------------------------------------------------------
interface fpec_if;
  logic reg_wr;          // Register write strobe, one cycle
  logic reg_sel;         // Control or key register
  logic [15:0] reg_wdata; // Register write data
  logic tbl_wr;          // Table write strobe, one cycle
  logic [23:0] tbl_addr; // Table write program address
  logic [23:0] tbl_data; // Table write instruction word
  logic [15:0] reg_rdata; // Control register mirror
  logic stall;           // Core must wait while high

  modport ctrl (
    input reg_wr, reg_sel, reg_wdata, tbl_wr, tbl_addr, tbl_data,
    output reg_rdata, stall
  );

  modport core (
    output reg_wr, reg_sel, reg_wdata, tbl_wr, tbl_addr, tbl_data,
    input reg_rdata, stall
  );
endinterface : fpec_if

/* File: fpec_latch_bank.sv */
// --------------------------------------------------------------------
// Holding latches for one row of instructions
// --------------------------------------------------------------------
module fpec_latch_bank (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic wr, // Latch write strobe
  input wire logic [fpec_pkg::LATCH_IDX_W-1:0] wr_idx, // Latch written
  input wire logic [fpec_pkg::INSTR_W-1:0] wr_data, // Word written
  input wire logic [fpec_pkg::LATCH_IDX_W-1:0] rd_idx, // Latch read by flash
  output logic [fpec_pkg::INSTR_W-1:0] rd_data // Word read by flash
);

  typedef struct packed {
    logic [fpec_pkg::ROW_WORDS-1:0][fpec_pkg::INSTR_W-1:0] mem; // Latch flops
  } fpec_lb_state_t;

  fpec_lb_state_t q; // Registered state
  fpec_lb_state_t d; // Next state

  // ----------------------------------------------------------------
  // Next state: a later write to the same latch wipes the earlier one
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (wr) begin
      d.mem[wr_idx] = wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Registers; reset to erased value so unused slots do not corrupt
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q.mem <= {fpec_pkg::ROW_WORDS{fpec_pkg::ERASED_WORD}};
    end else begin
      q <= d;
    end
  end

  // Flash macro reads any latch while the operation runs
  assign rd_data = q.mem[rd_idx];

endmodule : fpec_latch_bank

/* File: fpec_ctrl.sv */
// --------------------------------------------------------------------
// Flash program/erase controller, device end of the link
// --------------------------------------------------------------------
//
// Local design decisions: the Avalon-MM slave port and the address map.
module fpec_ctrl #(
  parameter logic [15:0] WORD_CYC = 16'h0040, // Word program cycles
  parameter logic [15:0] ROW_CYC = 16'h0400, // Row program cycles
  parameter logic [15:0] PAGE_CYC = 16'h0800, // Page erase cycles
  parameter logic [15:0] BULK_CYC = 16'h1000 // Bulk erase cycles
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Power-on reset, synchronous, active low
  input wire logic sys_rst_n, // Any other reset, synchronous, active low
  input wire logic ser_prog_mode, // Serial programming mode active
  fpec_if.ctrl link, // Link to processor core
  output fpec_pkg::fpec_kind_t fl_kind, // Operation driven to flash array
  output logic [fpec_pkg::ADDR_W-1:0] fl_addr, // Target address, aligned for row and page
  input wire logic [fpec_pkg::LATCH_IDX_W-1:0] fl_latch_idx, // Latch read index
  output logic [fpec_pkg::INSTR_W-1:0] fl_latch_data // Latch read data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start; // Operation running
    logic en; // Write enable
    logic err; // Sequence error flag
    logic erase; // Erase select
    logic [3:0] op; // Operation code
    fpec_pkg::fpec_key_t key; // Unlock progress
    fpec_pkg::fpec_dstate_t st; // Sequencer state
    fpec_pkg::fpec_kind_t kind; // Operation in flight
    logic [fpec_pkg::CNT_W-1:0] cnt; // Cycles left
    logic [fpec_pkg::ADDR_W-1:0] taddr; // Last table write address
    logic [fpec_pkg::ADDR_W-1:0] faddr; // Target address of operation
    logic [15:0] rdata; // Control register mirror
  } fpec_ctrl_state_t;

  localparam fpec_ctrl_state_t RESET_STATE = '{
    start: 1'b0,
    en: 1'b0,
    err: 1'b0,
    erase: 1'b0,
    op: 4'h0,
    key: fpec_pkg::FPEC_KS_IDLE,
    st: fpec_pkg::FPEC_DS_IDLE,
    kind: fpec_pkg::FPEC_K_NONE,
    cnt: 16'h0000,
    taddr: 24'h000000,
    faddr: 24'h000000,
    rdata: fpec_pkg::CTL_RESET
  };

  fpec_ctrl_state_t q; // Registered state
  fpec_ctrl_state_t d; // Next state

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Timer load for each kind; the count runs down to zero
  function automatic logic [15:0] kind_cycles(input fpec_pkg::fpec_kind_t k);
    logic [15:0] c;
    c = WORD_CYC;
    unique case (k)
      fpec_pkg::FPEC_K_ROW: c = ROW_CYC;
      fpec_pkg::FPEC_K_PAGE: c = PAGE_CYC;
      fpec_pkg::FPEC_K_BULK: c = BULK_CYC;
      default: c = WORD_CYC;
    endcase
    return c - 16'h0001;
  endfunction : kind_cycles

  // Address handed to the array, aligned to the row or page for those kinds; word and bulk pass it unchanged
  function automatic logic [23:0] kind_addr(input fpec_pkg::fpec_kind_t k,
                                            input logic [23:0] a);
    logic [23:0] r;
    r = a;
    if (k == fpec_pkg::FPEC_K_ROW) begin
      r = a & fpec_pkg::ROW_MASK;
    end else if (k == fpec_pkg::FPEC_K_PAGE) begin
      r = a & fpec_pkg::PAGE_MASK;
    end
    return r;
  endfunction : kind_addr

  logic start_req; // Control write asks for start
  fpec_pkg::fpec_kind_t req_kind; // Decoded request
  logic [3:0] wr_op; // Op code in write data
  logic [$bits(fpec_pkg::KEY_FIRST)-1:0] key_val; // Key byte in write data

  // Only the low byte carries the key; upper bits are ignored
  assign key_val = link.reg_wdata[$bits(fpec_pkg::KEY_FIRST)-1:0];
  assign wr_op = link.reg_wdata[fpec_pkg::CTL_OP_LSB +: fpec_pkg::CTL_OP_W];
  assign start_req = link.reg_wdata[fpec_pkg::CTL_START_BIT];
  // Bulk erase only decodes while serial programming mode is on
  assign req_kind = fpec_pkg::fpec_decode(wr_op,
                      link.reg_wdata[fpec_pkg::CTL_ERASE_BIT], ser_prog_mode);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Table writes only land in the latches and the pointer copy
    if (link.tbl_wr) begin
      d.taddr = link.tbl_addr;
    end
    unique case (q.st)
      fpec_pkg::FPEC_DS_IDLE: begin
        if (!sys_rst_n) begin
          // Other resets drop unlock progress but keep control bits
          d.key = fpec_pkg::FPEC_KS_IDLE;
        end else if (link.reg_wr && link.reg_sel == fpec_pkg::REG_SEL_KEY) begin
          // Key writes only advance the unlock tracker, nothing stored
          if (key_val == fpec_pkg::KEY_FIRST) begin
            d.key = fpec_pkg::FPEC_KS_FIRST;
          end else if (key_val == fpec_pkg::KEY_SECOND &&
                       q.key == fpec_pkg::FPEC_KS_FIRST) begin
            d.key = fpec_pkg::FPEC_KS_ARMED;
          end else begin
            d.key = fpec_pkg::FPEC_KS_IDLE; // Broken sequence
          end
        end else if (link.reg_wr) begin
          // Any control write uses up the unlock, successful or not
          d.key = fpec_pkg::FPEC_KS_IDLE;
          d.en = link.reg_wdata[fpec_pkg::CTL_EN_BIT];
          d.erase = link.reg_wdata[fpec_pkg::CTL_ERASE_BIT];
          d.op = wr_op;
          if (start_req) begin
            if (q.key == fpec_pkg::FPEC_KS_ARMED &&
                link.reg_wdata[fpec_pkg::CTL_EN_BIT] &&
                req_kind != fpec_pkg::FPEC_K_NONE) begin
              // Accepted: launch the timed operation
              d.start = 1'b1;
              d.err = 1'b0;
              d.st = fpec_pkg::FPEC_DS_BUSY;
              d.kind = req_kind;
              d.cnt = kind_cycles(req_kind);
              d.faddr = kind_addr(req_kind, q.taddr);
            end else begin
              // Refused: no lock, no enable or no valid operation
              d.err = 1'b1;
            end
          end
        end
      end
      fpec_pkg::FPEC_DS_BUSY: begin
        if (!sys_rst_n) begin
          // Reset mid-operation terminates it and flags the abort
          d.start = 1'b0;
          d.err = 1'b1;
          d.st = fpec_pkg::FPEC_DS_IDLE;
          d.kind = fpec_pkg::FPEC_K_NONE;
          d.key = fpec_pkg::FPEC_KS_IDLE;
        end else if (q.cnt == '0) begin
          // Self-timed end; start clearing is the only completion sign
          d.start = 1'b0;
          d.st = fpec_pkg::FPEC_DS_IDLE;
          d.kind = fpec_pkg::FPEC_K_NONE;
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end
      default: begin
        d.st = fpec_pkg::FPEC_DS_IDLE; // Illegal code recovers
      end
    endcase
    // Mirror for reads; unimplemented bits stay zero
    d.rdata = '0;
    d.rdata[fpec_pkg::CTL_START_BIT] = d.start;
    d.rdata[fpec_pkg::CTL_EN_BIT] = d.en;
    d.rdata[fpec_pkg::CTL_ERR_BIT] = d.err;
    d.rdata[fpec_pkg::CTL_ERASE_BIT] = d.erase;
    d.rdata[fpec_pkg::CTL_OP_LSB +: fpec_pkg::CTL_OP_W] = d.op;
  end

  // ----------------------------------------------------------------
  // Registers; only power-on reset returns control bits to zero
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Holding latches
  // ----------------------------------------------------------------
  fpec_latch_bank u_latch (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr(link.tbl_wr),
    .wr_idx(link.tbl_addr[fpec_pkg::LATCH_IDX_LSB +: fpec_pkg::LATCH_IDX_W]),
    .wr_data(link.tbl_data),
    .rd_idx(fl_latch_idx),
    .rd_data(fl_latch_data)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Stall follows the running flag so the core cannot race the array
  assign link.stall = q.start;
  assign link.reg_rdata = q.rdata;
  assign fl_kind = q.kind;
  assign fl_addr = q.faddr;

endmodule : fpec_ctrl

/* File: fpec_core.sv */
// --------------------------------------------------------------------
// Processor core end: Avalon-MM slave that drives the link
// --------------------------------------------------------------------
module fpec_core (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Hold request while high
  fpec_if.core link // Link to controller
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] gap; // Idle slots left after a register write
    logic [23:0] taddr; // Table pointer, steps per data write
    logic reg_wr; // Link register strobe
    logic reg_sel; // Link register select
    logic [15:0] reg_wdata; // Link register data
    logic tbl_wr; // Link table strobe
    logic [23:0] tbl_addr; // Link table address
    logic [23:0] tbl_data; // Link table data
  } fpec_core_state_t;

  fpec_core_state_t q; // Registered state
  fpec_core_state_t d; // Next state
  logic accept; // Request taken this edge

  // Core waits while the array works and during the idle slots
  assign avs_waitrequest = link.stall || (q.gap != 2'h0);
  assign accept = (avs_read || avs_write) && !avs_waitrequest;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.reg_wr = 1'b0;
    d.tbl_wr = 1'b0;
    if (q.gap != 2'h0) begin
      d.gap = q.gap - 2'h1;
    end
    if (accept && avs_write) begin
      unique case (avs_address)
        fpec_pkg::HOST_OFS_CTRL, fpec_pkg::HOST_OFS_KEY: begin
          // Key writes pass on like control writes and get the same idle slots below
          d.reg_wr = 1'b1;
          d.reg_sel = (avs_address == fpec_pkg::HOST_OFS_KEY) ?
                      fpec_pkg::REG_SEL_KEY : fpec_pkg::REG_SEL_CTRL;
          d.reg_wdata = avs_writedata[15:0];
          // Two idle slots let stall and the mirror catch up
          d.gap = fpec_pkg::HOST_NOP_SLOTS;
        end
        fpec_pkg::HOST_OFS_TADDR: begin
          d.taddr = avs_writedata[23:0];
        end
        fpec_pkg::HOST_OFS_TDATA: begin
          // One latch word per table write, pointer then steps
          d.tbl_wr = 1'b1;
          d.tbl_addr = q.taddr;
          d.tbl_data = avs_writedata[23:0];
          d.taddr = q.taddr + fpec_pkg::TBL_ADDR_STEP;
        end
        default: begin
          d.gap = q.gap; // Unmapped write ignored
          if (q.gap != 2'h0) begin
            d.gap = q.gap - 2'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, taken by the master at the accepting edge
  // ----------------------------------------------------------------
  always_comb begin
    avs_readdata = 32'h00000000;
    unique case (avs_address)
      fpec_pkg::HOST_OFS_CTRL: avs_readdata[15:0] = link.reg_rdata;
      fpec_pkg::HOST_OFS_TADDR: avs_readdata[23:0] = q.taddr;
      fpec_pkg::HOST_OFS_STAT: avs_readdata[fpec_pkg::STAT_STALL_BIT] = link.stall;
      default: avs_readdata = 32'h00000000; // Key and unmapped read zero
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.reg_wr = q.reg_wr;
  assign link.reg_sel = q.reg_sel;
  assign link.reg_wdata = q.reg_wdata;
  assign link.tbl_wr = q.tbl_wr;
  assign link.tbl_addr = q.tbl_addr;
  assign link.tbl_data = q.tbl_data;

endmodule : fpec_core

/* File: fpec_checker.sv */
module fpec_checker (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Power-on reset
  input wire logic reg_wr, // Register strobe
  input wire logic reg_sel, // Key select
  input wire logic [15:0] reg_wdata, // Register data
  input wire logic tbl_wr, // Table strobe
  input wire logic [15:0] reg_rdata, // Control mirror
  input wire logic stall // Core held
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // --------
  // Steps
  // --------
  sequence op_go; // Operation launched
    $rose(stall);
  endsequence
  sequence go_wr; // Start written while idle
    reg_wr && !reg_sel && reg_wdata[15] && !stall;
  endsequence
  // --------
  // Checks
  // --------
  stall_mirror_a: assert property (stall == reg_rdata[15])
    else $error("stall differs from start bit");
  unused_zero_a: assert property ({reg_rdata[12:7], reg_rdata[5:4]} == 8'h00)
    else $error("unused control bits set");
  start_code_a: assert property (op_go |->
    reg_rdata[6:0] inside {7'h03, 7'h01, 7'h42, 7'h4F}) else $error("bad code started");
  start_en_a: assert property (op_go |-> reg_rdata[14] && !reg_rdata[13])
    else $error("start without enable");
  start_cause_a: assert property (op_go |->
    $past(reg_wr && !reg_sel && reg_wdata[15])) else $error("start without write");
  op_bound_a: assert property (op_go |-> ##[1:7] !stall)
    else $error("operation too long");
  refuse_err_a: assert property (go_wr ##1 !stall |-> reg_rdata[13])
    else $error("refused start left no error");
  tbl_latch_a: assert property (tbl_wr && !stall |=> !stall)
    else $error("table write started work");
  key_hidden_a: assert property (reg_wr && reg_sel |=> $stable(reg_rdata))
    else $error("key write changed control");
endmodule : fpec_checker

/* File: fpec_tb_top.sv */
module fpec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic ser; // Serial mode
    logic [15:0] w; // Control word
    logic [4:0] k; // Expected kind
    logic [7:0] cyc; // Busy cycles
    logic [15:0] rb; // Readback
  } fpec_row_t;
  logic ref_clk, rst_n, sys_rst_n, ser_prog_mode; // Drives
  logic [4:0] avs_address; // Bus address
  logic avs_read, avs_write, avs_waitrequest; // Bus strobes
  logic [31:0] avs_writedata, avs_readdata, rd; // Bus data
  logic [5:0] fl_latch_idx; // Latch probe
  logic [23:0] fl_addr, fl_latch_data, last_a; // Flash side
  fpec_pkg::fpec_kind_t fl_kind, last_k; // Operation kind
  int fails = 0, n_checks = 0, nst = 0, s0; // Counters
  fpec_row_t rows [11]; // Ordinary cases
  fpec_if lnk ();
  fpec_core u_fpec_core (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(lnk.core));
  // Short counts keep the run brief
  fpec_ctrl #(.WORD_CYC(16'h0004), .ROW_CYC(16'h0005), .PAGE_CYC(16'h0006),
    .BULK_CYC(16'h0007)) u_fpec_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .sys_rst_n(sys_rst_n), .ser_prog_mode(ser_prog_mode), .link(lnk.ctrl),
    .fl_kind(fl_kind), .fl_addr(fl_addr), .fl_latch_idx(fl_latch_idx),
    .fl_latch_data(fl_latch_data));
  fpec_checker u_fpec_checker (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(lnk.reg_wr),
    .reg_sel(lnk.reg_sel), .reg_wdata(lnk.reg_wdata), .tbl_wr(lnk.tbl_wr),
    .reg_rdata(lnk.reg_rdata), .stall(lnk.stall));
  initial begin // Clock
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin // Busy cycles, last kind and target
    if (lnk.stall === 1'h1) nst <= nst + 1;
    if (fl_kind !== fpec_pkg::FPEC_K_NONE) begin
      last_k <= fl_kind;
      last_a <= fl_addr;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Called just after a rising edge; held until waitrequest is low at an edge
  // Bus outputs read right after the edge still show their pre-edge values
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 400);
    rd = avs_readdata;
    if (n >= 400) fails++;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge ref_clk); // Idle edge so strobes are never set twice in one step
  endtask : bus
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin // Watchdog, far past the expected run
    repeat (4000) @(posedge ref_clk);
    fails++;
    end_sim;
  end
  initial begin // Tests
    rst_n = 1'h0;
    sys_rst_n = 1'h1;
    ser_prog_mode = 1'h0;
    fl_latch_idx = 6'h05;
    avs_address = 5'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    rows = '{'{1'h0,16'h4003,5'h02,8'h04,16'h4003}, '{1'h0,16'h4001,5'h04,8'h05,16'h4001},
      '{1'h0,16'h4042,5'h08,8'h06,16'h4042}, '{1'h1,16'h404F,5'h10,8'h07,16'h404F},
      '{1'h0,16'h404F,5'h01,8'h00,16'h604F}, '{1'h1,16'h400F,5'h01,8'h00,16'h600F},
      '{1'h0,16'h4043,5'h01,8'h00,16'h6043}, '{1'h0,16'h4002,5'h01,8'h00,16'h6002},
      '{1'h0,16'h4005,5'h01,8'h00,16'h6005}, '{1'h0,16'h0003,5'h01,8'h00,16'h2003},
      '{1'h0,16'hFFB3,5'h02,8'h04,16'h4003}};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    bus(1'h0, 5'h10, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 11; i++) begin // Unlock then start each row
      ser_prog_mode <= rows[i].ser;
      s0 = nst;
      bus(1'h1, 5'h04, 32'h55);
      bus(1'h1, 5'h04, 32'hAA);
      bus(1'h1, 5'h00, {16'h0000, 1'h1, rows[i].w[14:0]});
      bus(1'h0, 5'h00, 32'h0);
      chk(rd, {16'h0000, rows[i].rb});
      chk(32'(nst - s0), 32'(rows[i].cyc));
      if (rows[i].cyc != 8'h00) chk(32'(last_k), 32'(rows[i].k));
      $display("row %0d done", i);
    end
    // Control write between the keys spoils the unlock
    s0 = nst;
    bus(1'h1, 5'h04, 32'h55);
    bus(1'h1, 5'h00, 32'h4003);
    bus(1'h1, 5'h04, 32'hAA);
    bus(1'h1, 5'h00, 32'hC003);
    bus(1'h0, 5'h00, 32'h0);
    chk(rd, 32'h6003);
    chk(32'(nst - s0), 32'h0);
    $display("broken unlock done");
    // Page erase with a table write between the keys
    bus(1'h1, 5'h08, 32'h150A);
    s0 = nst;
    bus(1'h1, 5'h04, 32'h55);
    bus(1'h1, 5'h0C, 32'h123456);
    bus(1'h1, 5'h04, 32'hAA);
    bus(1'h1, 5'h00, 32'hC042);
    bus(1'h0, 5'h08, 32'h0);
    chk(32'(nst - s0), 32'h6);
    chk(32'(last_a), 32'h1400);
    chk(32'(fl_latch_data), 32'h123456);
    chk(rd, 32'h150C);
    bus(1'h0, 5'h04, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, 5'h14, 32'hFFFF);
    bus(1'h0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    $display("page erase done");
    // Other reset in mid-operation aborts but keeps fields
    bus(1'h1, 5'h04, 32'h55);
    bus(1'h1, 5'h04, 32'hAA);
    fork
      bus(1'h1, 5'h00, 32'hC001);
      begin
        repeat (4) @(posedge ref_clk);
        sys_rst_n <= 1'h0;
        @(posedge ref_clk);
        sys_rst_n <= 1'h1;
      end
    join
    bus(1'h0, 5'h00, 32'h0);
    chk(rd, 32'h6001);
    $display("abort done");
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    bus(1'h0, 5'h00, 32'h0);
    chk(rd, 32'h0);
    chk(32'(fl_latch_data), 32'hFFFFFF);
    $display("power-on reset done");
    end_sim;
  end
endmodule : fpec_tb_top
